// ### tributary_flags_pkg.sv
// Shared constants for the tributary event flag bank
package tributary_flags_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_BANKS = 3;
   localparam int NUM_TRIBS = 7;
   localparam int NUM_KINDS = 4;
   localparam int LABEL_W = 3;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_LABEL_CHANGE_FLAGS_A = 10'h138;
   localparam logic [IDX_W-1:0] IDX_LABEL_MISMATCH_FLAGS_A = 10'h139;
   localparam logic [IDX_W-1:0] IDX_LABEL_UNSTABLE_FLAGS_A = 10'h13A;
   localparam logic [IDX_W-1:0] IDX_REMOTE_DEFECT_FLAGS_A = 10'h13B;
   localparam logic [IDX_W-1:0] IDX_LABEL_CHANGE_FLAGS_B = 10'h238;
   localparam logic [IDX_W-1:0] IDX_LABEL_MISMATCH_FLAGS_B = 10'h239;
   localparam logic [IDX_W-1:0] IDX_LABEL_UNSTABLE_FLAGS_B = 10'h23A;
   localparam logic [IDX_W-1:0] IDX_REMOTE_DEFECT_FLAGS_B = 10'h23B;
   localparam logic [IDX_W-1:0] IDX_LABEL_CHANGE_FLAGS_C = 10'h338;
   localparam logic [IDX_W-1:0] IDX_LABEL_MISMATCH_FLAGS_C = 10'h339;
   localparam logic [IDX_W-1:0] IDX_LABEL_UNSTABLE_FLAGS_C = 10'h33A;
   localparam logic [IDX_W-1:0] IDX_REMOTE_DEFECT_FLAGS_C = 10'h33B;

   // Bank selector field of an index (banks a, b, c are 1, 2, 3)
   localparam int BANK_SEL_MSB = 9;
   localparam int BANK_SEL_LSB = 8;
   localparam logic [1:0] BANK_SEL_A = 2'h1;

   // Offsets inside a bank
   localparam logic [7:0] OFS_FLAGS_FIRST = 8'h38;
   localparam logic [7:0] OFS_CTRL = 8'hF0;
   localparam logic [7:0] OFS_ENABLE = 8'hF1;
   localparam logic [7:0] OFS_EXPECTED = 8'hF2;
   localparam logic [7:0] OFS_ACCEPTED = 8'hF3;

   // ------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------
   localparam int RESERVED_BIT = 7;
   localparam int CTRL_TU3_BIT = 0;
   localparam int CTRL_EXT_LSB = 1;
   localparam int ENABLE_STRIDE = 8;
   localparam int TRIB_FIELD_W = 7;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
   localparam logic [20:0] EXPECTED_RST = 21'h00_0000;
   localparam logic [LABEL_W-1:0] LABEL_RST = 3'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam logic [2:0] ACCEPT_FRAMES = 3'h5;
   localparam logic [2:0] RUN_FIRST = 3'h1;

   // ------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FLAG_CHANGE = 2'b00,
      FLAG_MISMATCH = 2'b01,
      FLAG_UNSTABLE = 2'b10,
      FLAG_REMOTE = 2'b11
   } flag_kind_e;

   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_ANSWER = 2'b01
   } apb_state_e;

endpackage

// ### trib_event_if.sv
// Carrier between the flag bank and one tributary tracker
`timescale 1ns/1ps
interface trib_event_if;
   logic tu3_mode;
   logic [6:0] ext_sel;
   logic [20:0] expected;
   logic [20:0] accepted;
   logic [6:0] label_change_ev;
   logic [6:0] label_mismatch_ev;
   logic [6:0] label_unstable_ev;
   logic [6:0] remote_defect_ev;

   modport ctl (
      output tu3_mode,
      output ext_sel,
      output expected,
      input accepted,
      input label_change_ev,
      input label_mismatch_ev,
      input label_unstable_ev,
      input remote_defect_ev
   );

   modport trib (
      input tu3_mode,
      input ext_sel,
      input expected,
      output accepted,
      output label_change_ev,
      output label_mismatch_ev,
      output label_unstable_ev,
      output remote_defect_ev
   );
endinterface

// ### tributary_overhead_tracker.sv
// Label acceptance, mismatch, stability and remote defect tracking for seven tributaries
`timescale 1ns/1ps
module tributary_overhead_tracker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [6:0] label_strobe,
   input wire logic [6:0][2:0] label_rx,
   input wire logic [6:0] v5_rdi,
   input wire logic [6:0][2:0] z7_code,
   trib_event_if.trib bus
);
   genvar t;
   generate
      for (t = 0; t < tributary_flags_pkg::NUM_TRIBS; t++) begin : g_trib
         logic [2:0] last_r;
         logic [2:0] run_r;
         logic [2:0] acc_r;
         logic unst_r;
         logic mism_r;
         logic [2:0] rdi_r;
         logic [2:0] run_nxt;
         logic same;
         logic accept;
         logic unst_nxt;
         logic mism_now;
         logic [2:0] rdi_now;
         logic chg_ev_r;
         logic mism_ev_r;
         logic unst_ev_r;
         logic rdi_ev_r;

         // Run length of identical received labels
         assign same = label_rx[t] == last_r;
         assign run_nxt = !same ? tributary_flags_pkg::RUN_FIRST :
                          (run_r == tributary_flags_pkg::ACCEPT_FRAMES) ? run_r : 3'(run_r + 3'h1);
         assign accept = label_strobe[t] && run_nxt == tributary_flags_pkg::ACCEPT_FRAMES;
         // Unstable while a differing label has not yet been accepted
         assign unst_nxt = !label_strobe[t] ? unst_r : accept ? 1'b0 : (label_rx[t] != acc_r) ? 1'b1 : unst_r;
         assign mism_now = acc_r != bus.expected[3*t +: 3];
         assign rdi_now = bus.ext_sel[t] ? z7_code[t] : {2'h0, v5_rdi[t]};

         // Per-tributary state
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               last_r <= tributary_flags_pkg::LABEL_RST;
               run_r <= 3'h0;
               acc_r <= tributary_flags_pkg::LABEL_RST;
               unst_r <= 1'b0;
            end else if (label_strobe[t]) begin
               last_r <= label_rx[t];
               run_r <= run_nxt;
               unst_r <= unst_nxt;
               if (accept) begin
                  acc_r <= label_rx[t];
               end
            end
         end

         // Change detectors, one-cycle event pulses
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               mism_r <= 1'b0;
               rdi_r <= 3'h0;
               chg_ev_r <= 1'b0;
               mism_ev_r <= 1'b0;
               unst_ev_r <= 1'b0;
               rdi_ev_r <= 1'b0;
            end else begin
               mism_r <= mism_now;
               rdi_r <= rdi_now;
               chg_ev_r <= accept && label_rx[t] != acc_r;
               mism_ev_r <= mism_now != mism_r;
               unst_ev_r <= unst_nxt != unst_r;
               rdi_ev_r <= rdi_now != rdi_r;
            end
         end

         assign bus.accepted[3*t +: 3] = acc_r;
         assign bus.label_change_ev[t] = chg_ev_r;
         assign bus.label_mismatch_ev[t] = mism_ev_r;
         assign bus.label_unstable_ev[t] = unst_ev_r;
         assign bus.remote_defect_ev[t] = rdi_ev_r;
      end
   endgenerate
endmodule

// ### tributary_label_rdi_event_flags.sv
// Tributary label and remote defect event flag banks with APB access and interrupt
`timescale 1ns/1ps
module tributary_label_rdi_event_flags (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [2:0][6:0] label_strobe,
   input wire logic [2:0][6:0][2:0] label_rx,
   input wire logic [2:0][6:0] v5_rdi,
   input wire logic [2:0][6:0][2:0] z7_code
);

   // ------------------------------------------------------------
   // Register map, word index within a bank
   // ------------------------------------------------------------
   // Banks at 0x100, 0x200 and 0x300
   // 0x38 change flags, bit 7 reserved
   // 0x39 mismatch flags
   // 0x3A unstable flags
   // 0x3B remote defect flags
   // 0xF0 bit 0 single stream, 7:1 code select
   // 0xF1 enables, a byte lane per kind
   // 0xF2 expected labels, 3 bits each
   // 0xF3 accepted labels, read only
   // Other indices refused with pslverr
   // Unused upper bits read zero
   // Flags clear on read or a written one
   // Set wins over a same-cycle clear

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Visible tributary bits of a flag kind, zeroed above bit 0 in TU3 mode
   // Unstable flags stay live for all
   function automatic logic [6:0] tu3_view(input logic [6:0] bits, input logic tu3, input logic [1:0] kind);
      logic keep_all;
      keep_all = !tu3 || kind == tributary_flags_pkg::FLAG_UNSTABLE;
      tu3_view = keep_all ? bits : {6'h00, bits[0]};
   endfunction

   // Byte-lane merge of a write into a stored word
   // Lanes without a strobe keep old bytes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      lane_merge = res;
   endfunction

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // Flags, settings, events and read path,
   // indexed by bank; flags and events then by flag kind
   logic [7:0] flags_r [tributary_flags_pkg::NUM_BANKS][tributary_flags_pkg::NUM_KINDS];
   logic [7:0] flags_nxt [tributary_flags_pkg::NUM_BANKS][tributary_flags_pkg::NUM_KINDS];

   logic [7:0] ctrl_r [tributary_flags_pkg::NUM_BANKS];
   logic [31:0] enable_r [tributary_flags_pkg::NUM_BANKS];
   logic [20:0] expected_r [tributary_flags_pkg::NUM_BANKS];

   logic [6:0] ev_set [tributary_flags_pkg::NUM_BANKS][tributary_flags_pkg::NUM_KINDS];
   logic [6:0] vis [tributary_flags_pkg::NUM_BANKS][tributary_flags_pkg::NUM_KINDS];
   logic [6:0] pend [tributary_flags_pkg::NUM_BANKS][tributary_flags_pkg::NUM_KINDS];

   logic [31:0] bank_rd [tributary_flags_pkg::NUM_BANKS];
   logic bank_hit [tributary_flags_pkg::NUM_BANKS];

   // Answer state and output flops
   tributary_flags_pkg::apb_state_e state_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;

   // One carrier per bank to its tracker
   trib_event_if bank_if [tributary_flags_pkg::NUM_BANKS] ();

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic [9:0] idx;
   logic [1:0] bank_sel;
   logic [7:0] ofs;
   logic is_flag_reg;
   logic [1:0] flag_kind;

   logic rd_hit;
   logic [31:0] rd_data;

   logic access_start;
   logic access_done;
   logic wr_fire;
   logic rd_fire;

   // Word index split into bank and offset;
   // address bits 1:0 are ignored
   assign idx = paddr[11:2];
   assign bank_sel = idx[tributary_flags_pkg::BANK_SEL_MSB:tributary_flags_pkg::BANK_SEL_LSB];
   assign ofs = idx[7:0];
   assign is_flag_reg = ofs[7:2] == tributary_flags_pkg::OFS_FLAGS_FIRST[7:2];
   assign flag_kind = ofs[1:0];

   // Read mux across banks; an unselected
   // bank gives zero, so an OR merges them
   assign rd_data = bank_rd[0] | bank_rd[1] | bank_rd[2];
   assign rd_hit = bank_hit[0] || bank_hit[1] || bank_hit[2];

   // Transfer phases: the first access cycle
   // captures, the second answers and commits
   assign access_start = psel && penable && state_r == tributary_flags_pkg::APB_IDLE;
   assign access_done = psel && penable && state_r == tributary_flags_pkg::APB_ANSWER;
   assign wr_fire = access_done && pwrite && !pslverr_r;
   assign rd_fire = access_done && !pwrite && !pslverr_r;

   // ------------------------------------------------------------
   // Per-bank logic
   // ------------------------------------------------------------
   // Three banks, each with its own tracker
   genvar b, k;
   generate
      for (b = 0; b < tributary_flags_pkg::NUM_BANKS; b++) begin : g_bank
         logic sel;
         logic [31:0] ctrl_word;
         logic [31:0] enable_word;
         logic [31:0] expected_word;
         logic [31:0] accepted_word;
         logic [31:0] flag_word;
         logic ofs_known;

         // This bank answers its own index block
         assign sel = bank_sel == 2'(b + tributary_flags_pkg::BANK_SEL_A);

         // Settings handed to the tracker
         assign bank_if[b].tu3_mode = ctrl_r[b][tributary_flags_pkg::CTRL_TU3_BIT];
         assign bank_if[b].ext_sel = ctrl_r[b][tributary_flags_pkg::CTRL_EXT_LSB +: 7];
         assign bank_if[b].expected = expected_r[b];

         // Event inputs per flag kind,
         // one-cycle pulses from the tracker
         assign ev_set[b][tributary_flags_pkg::FLAG_CHANGE] = bank_if[b].label_change_ev;
         assign ev_set[b][tributary_flags_pkg::FLAG_MISMATCH] = bank_if[b].label_mismatch_ev;
         assign ev_set[b][tributary_flags_pkg::FLAG_UNSTABLE] = bank_if[b].label_unstable_ev;
         assign ev_set[b][tributary_flags_pkg::FLAG_REMOTE] = bank_if[b].remote_defect_ev;

         // Label and defect tracking
         tributary_overhead_tracker u_tracker (
            .clk(clk),
            .arst_n(arst_n),
            .label_strobe(label_strobe[b]),
            .label_rx(label_rx[b]),
            .v5_rdi(v5_rdi[b]),
            .z7_code(z7_code[b]),
            .bus(bank_if[b])
         );

         // Read views of the bank registers;
         // labels are three bits per tributary
         assign ctrl_word = {24'h00_0000, ctrl_r[b]};
         assign enable_word = enable_r[b];
         assign expected_word = {11'h000, expected_r[b]};
         assign accepted_word = {11'h000, bank_if[b].accepted};
         // Single stream mode hides bits 1 to 6, except in the unstable flags
         assign flag_word = {24'h00_0000, flags_r[b][flag_kind][tributary_flags_pkg::RESERVED_BIT],
                             vis[b][flag_kind]};
         assign ofs_known = is_flag_reg || ofs == tributary_flags_pkg::OFS_CTRL ||
                            ofs == tributary_flags_pkg::OFS_ENABLE || ofs == tributary_flags_pkg::OFS_EXPECTED ||
                            ofs == tributary_flags_pkg::OFS_ACCEPTED;
         assign bank_hit[b] = sel && ofs_known;
         assign bank_rd[b] = !sel ? 32'h0000_0000 :
                             is_flag_reg ? flag_word :
                             ofs == tributary_flags_pkg::OFS_CTRL ? ctrl_word :
                             ofs == tributary_flags_pkg::OFS_ENABLE ? enable_word :
                             ofs == tributary_flags_pkg::OFS_EXPECTED ? expected_word :
                             ofs == tributary_flags_pkg::OFS_ACCEPTED ? accepted_word : 32'h0000_0000;

         // One flag register per kind
         for (k = 0; k < tributary_flags_pkg::NUM_KINDS; k++) begin : g_kind
            logic hit;
            logic [6:0] set;
            logic [6:0] clr;
            logic [6:0] en;

            assign hit = sel && is_flag_reg && flag_kind == 2'(k);
            // Events are recorded whatever the enables say
            assign set = tu3_view(ev_set[b][k], bank_if[b].tu3_mode, 2'(k));
            // Read clears exactly what was returned; a one written also clears
            // An event between capture and answer was not
            // returned, so it stays for the next read
            assign clr = (rd_fire && hit) ? prdata_r[6:0] :
                         (wr_fire && hit && pstrb[0]) ? pwdata[6:0] : 7'h00;
            // Set wins over a clear in the same cycle
            assign flags_nxt[b][k][6:0] = (flags_r[b][k][6:0] & ~clr) | set;
            if (k == tributary_flags_pkg::FLAG_CHANGE) begin : g_rsvd
               // Reserved read-write bit, expected to stay zero
               assign flags_nxt[b][k][tributary_flags_pkg::RESERVED_BIT] = (wr_fire && hit && pstrb[0]) ?
                  pwdata[tributary_flags_pkg::RESERVED_BIT] : flags_r[b][k][tributary_flags_pkg::RESERVED_BIT];
            end else begin : g_unused
               // Other kinds have no bit 7
               assign flags_nxt[b][k][tributary_flags_pkg::RESERVED_BIT] = 1'b0;
            end

            // Bits shown in the current mode, and
            // the enabled ones among them
            assign vis[b][k] = tu3_view(flags_r[b][k][6:0], bank_if[b].tu3_mode, 2'(k));
            assign en = enable_r[b][k*tributary_flags_pkg::ENABLE_STRIDE +: tributary_flags_pkg::TRIB_FIELD_W];
            assign pend[b][k] = vis[b][k] & en;

            // Flag storage; reset clears
            // every flag and the reserved bit
            always_ff @(posedge clk or negedge arst_n) begin
               if (!arst_n) begin
                  flags_r[b][k] <= tributary_flags_pkg::FLAGS_RST;
               end else begin
                  flags_r[b][k] <= flags_nxt[b][k];
               end
            end
         end

         // Configuration registers; bit 7 of
         // each enable lane is dropped, reads zero
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               ctrl_r[b] <= tributary_flags_pkg::CTRL_RST;
               enable_r[b] <= tributary_flags_pkg::ENABLE_RST;
               expected_r[b] <= tributary_flags_pkg::EXPECTED_RST;
            end else if (wr_fire && sel) begin
               if (ofs == tributary_flags_pkg::OFS_CTRL && pstrb[0]) begin
                  ctrl_r[b] <= pwdata[7:0];
               end
               if (ofs == tributary_flags_pkg::OFS_ENABLE) begin
                  enable_r[b] <= lane_merge(enable_r[b], pwdata, pstrb) & 32'h7F7F_7F7F;
               end
               if (ofs == tributary_flags_pkg::OFS_EXPECTED) begin
                  expected_r[b] <= 21'(lane_merge(expected_word, pwdata, pstrb));
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   logic irq_nxt;

   // Any enabled, visible flag in any bank;
   // a set bit in a masked lane is ignored
   always_comb begin
      irq_nxt = 1'b0;
      for (int i = 0; i < tributary_flags_pkg::NUM_BANKS; i++) begin
         for (int j = 0; j < tributary_flags_pkg::NUM_KINDS; j++) begin
            irq_nxt = irq_nxt || (|pend[i][j]);
         end
      end
   end

   // Registered interrupt level: follows a
   // flag or enable a cycle late and drops
   // a cycle after the last enabled clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // ------------------------------------------------------------
   // APB slave: one wait state, then answer
   // ------------------------------------------------------------
   // The first access cycle captures data
   // and error, keeping prdata a flop; the
   // second answers. Writes and clears act
   // on that edge only; refusals are inert.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= tributary_flags_pkg::APB_IDLE;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         case (state_r)
            tributary_flags_pkg::APB_IDLE: begin
               if (access_start) begin
                  state_r <= tributary_flags_pkg::APB_ANSWER;
                  prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
                  pready_r <= 1'b1;
                  pslverr_r <= !rd_hit;
               end
            end
            tributary_flags_pkg::APB_ANSWER: begin
               state_r <= tributary_flags_pkg::APB_IDLE;
               pready_r <= 1'b0;
               pslverr_r <= 1'b0;
            end
            default: begin
               state_r <= tributary_flags_pkg::APB_IDLE;
               pready_r <= 1'b0;
               pslverr_r <= 1'b0;
            end
         endcase
      end
   end

   // Ports straight from the answer flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;

endmodule

// ### tributary_flags_props.sv
// Port-level checks for the tributary event flag bank
`timescale 1ns/1ps
module tributary_flags_props (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic irq
);
   logic [2:0] en_on_r;
   logic [7:0] ofs;
   logic done;

   // ------------------------------------------------------------
   // Helper decode
   // ------------------------------------------------------------
   // Offset in bank and completed transfer
   assign ofs = paddr[9:2];
   assign done = psel && penable && pready;

   // Banks holding any enable bit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_on_r <= 3'h0;
      end else if (done && pwrite && !pslverr && ofs == tributary_flags_pkg::OFS_ENABLE) begin
         en_on_r[paddr[11:10] - 2'h1] <= |pwdata;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   answer_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property (done && paddr[11:10] == 2'h0 |-> pslverr)
      else $error("unmapped access not refused");
   flag_width_a: assert property (done && !pwrite && !pslverr && ofs inside {8'h39, 8'h3A, 8'h3B}
      |-> prdata[31:7] == 25'h0)
      else $error("flag register upper bits set");
   change_width_a: assert property (done && !pwrite && !pslverr && ofs == 8'h38 |-> prdata[31:8] == 24'h0)
      else $error("change register upper bits set");
   write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data on a write");
   irq_masked_a: assert property ((en_on_r == 3'h0) [*2] |-> !irq)
      else $error("interrupt with all enables low");

   cover property (done && !pwrite);
   cover property (pslverr);
   cover property ($rose(irq));
endmodule

bind tributary_label_rdi_event_flags tributary_flags_props i_props (.clk, .arst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

// ### testbench.sv
// Self-checking bench for the tributary event flag bank
`timescale 1ns/1ps
module testbench;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [2:0][6:0] label_strobe, v5_rdi;
   logic [2:0][6:0][2:0] label_rx, z7_code;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [9:0] bb;
   logic [6:0] m;
   logic [2:0] lab;
   int err_total, n_checks;

   tributary_label_rdi_event_flags i_dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hF), .prdata, .pready, .pslverr, .irq, .label_strobe, .label_rx, .v5_rdi, .z7_code);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'hA300_0000) : (s >> 1);
   endfunction

   task automatic chk(input logic [32:0] seen, input logic [32:0] want);
      n_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One APB transfer, held until ready
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] idx, input logic [32:0] want);
      exp_q.push_back(want);
      apb(1'b0, idx, 32'h0);
   endtask

   task automatic strobe(input int b, input logic [6:0] mask, input int n);
      repeat (n) begin
         @(posedge clk);
         label_strobe[b] <= mask;
         @(posedge clk);
         label_strobe[b] <= 7'h00;
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic irq_is(input logic want);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({32'h0, irq}, {32'h0, want});
   endtask

   // ------------------------------------------------------------
   // Clock, read monitor, watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Compares each completed read with the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         chk({pslverr, e[32] ? 32'h0 : prdata}, e);
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, label_strobe, label_rx, v5_rdi, z7_code} = '0;
      arst_n = 1'b0;
      rnd = 32'h0001_6130;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int b = 0; b < 3; b++) begin
         bb = 10'h100 * 10'(b + 1);
         for (int k = 0; k < 4; k++) rd(bb | 10'(8'h38 + k), 33'h0);
         rnd = lfsr(rnd);
         m = rnd[6:0] | 7'h01;
         lab = 3'(rnd[9:8]) + 3'h1;
         apb(1'b1, bb | 10'h0F2, {11'h0, {7{lab}}});
         rd(bb | 10'h039, {26'h0, 7'h7F});
         apb(1'b1, bb | 10'h0F1, {25'h0, ~m});
         label_rx[b] <= {7{lab}};
         strobe(b, m, 4);
         rd(bb | 10'h038, 33'h0);
         strobe(b, m, 1);
         chk({32'h0, irq}, 33'h0);
         rd(bb | 10'h038, {26'h0, m});
         rd(bb | 10'h038, 33'h0);
         rd(bb | 10'h039, {26'h0, m});
         rd(bb | 10'h03A, {26'h0, m});
      end
      // Remote defect with interrupt enabled, then extended code on trib 3
      apb(1'b1, 10'h1F1, 32'h7F00_0000);
      v5_rdi[0] <= 7'h04;
      irq_is(1'b1);
      rd(10'h13B, {26'h0, 7'h04});
      irq_is(1'b0);
      apb(1'b1, 10'h1F0, 32'h0000_0010);
      z7_code[0][3] <= 3'h5;
      repeat (4) @(posedge clk);
      rd(10'h13B, {26'h0, 7'h08});
      v5_rdi[0] <= 7'h0C;
      repeat (4) @(posedge clk);
      rd(10'h13B, 33'h0);
      // Single stream mode in the last bank
      apb(1'b1, 10'h3F0, 32'h0000_0001);
      v5_rdi[2] <= 7'h7F;
      label_rx[2] <= {7{~lab}};
      strobe(2, 7'h7F, 5);
      rd(10'h338, {26'h0, 7'h01});
      rd(10'h33B, {26'h0, 7'h01});
      // Reserved bit kept low, unmapped access refused
      apb(1'b1, 10'h138, 32'h0);
      rd(10'h138, 33'h0);
      rd(10'h038, {1'b1, 32'h0});
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule
